// ==== pkg/alf_pkg.sv ====
package alf_pkg;

    // Control word numbers on the host write port
    localparam logic [4:0]  ALF_CW_LOOP      = 5'h08;
    localparam logic [4:0]  ALF_CW_LIMIT     = 5'h09;
    localparam logic [4:0]  ALF_CW_BE_RESET  = 5'h19;
    localparam logic [4:0]  ALF_CW_OPTION    = 5'h1b;

    // Field positions inside the control words
    localparam int          ALF_THR_HI       = 28;
    localparam int          ALF_THR_LO       = 16;
    localparam int          ALF_LG0_LO       = 0;
    localparam int          ALF_LG1_LO       = 8;
    localparam int          ALF_LIM_UP_HI    = 27;
    localparam int          ALF_LIM_UP_LO    = 16;
    localparam int          ALF_LIM_LO_HI    = 11;
    localparam int          ALF_LIM_LO_LO    = 0;
    localparam int          ALF_PROTECT_BIT  = 15;
    localparam int          ALF_MEDIAN_BIT   = 16;

    // Accumulator alignment
    localparam int          ALF_ACC_LIM_POS  = 19;
    localparam int          ALF_ERR_ALIGN    = 11;
    localparam logic [18:0] ALF_LIM_FILL     = 19'h7ffff;

    // Fixed median-mode errors, as 12-bit words
    localparam logic [11:0] ALF_MED_POS      = 12'h200;
    localparam logic [11:0] ALF_MED_NEG      = 12'he00;

    // Values after reset
    localparam logic [31:0] ALF_WORD_RST     = 32'h0000_0000;
    localparam logic [31:0] ALF_ACC_RST      = 32'h0000_0000;
    localparam logic [15:0] ALF_GAIN_RST     = 16'h0000;

    // Host control word write
    typedef struct packed {
        logic        wr;
        logic [4:0]  addr;
        logic [31:0] data;
    } alf_cw_t;

    // One stored loop gain: exponent above mantissa
    typedef struct packed {
        logic [3:0] exp;
        logic [3:0] mant;
    } alf_loop_gain_t;

    // Complete state of the loop filter
    typedef struct packed {
        logic [31:0] loop_q;
        logic [31:0] limit_q;
        logic        protect_q;
        logic        median_q;
        logic [1:0]  sel_sync_q;
        logic [1:0]  sync_sync_q;
        logic        sync_prev_q;
        logic [31:0] acc_q;
        logic [15:0] gain_q;
    } alf_state_t;

endpackage

// ==== verilog/alf_error_scaler.sv ====
`timescale 1ns/10ps
module alf_error_scaler (
    input  wire logic [12:0]           level_threshold,  // Programmed threshold
    input  wire logic [12:0]           signal_magnitude, // Polar converter magnitude
    input  wire logic                  median_mode,      // High selects fixed-step errors
    input  wire alf_pkg::alf_loop_gain_t loop_gain,      // Selected loop gain
    output logic signed [13:0]         gain_error,       // Error fed to scaling
    output logic signed [31:0]         acc_step          // Step in accumulator units
);
    logic signed [13:0] true_error;
    logic signed [18:0] product;
    logic signed [31:0] extended;
    logic [3:0]         shift_amt;

    assign true_error = $signed({1'b0, level_threshold}) - $signed({1'b0, signal_magnitude});

    // mean mode passes the true error; median picks a fixed value by sign
    always_comb begin
        if (median_mode) begin
            if (true_error[13]) begin
                gain_error = {{2{alf_pkg::ALF_MED_NEG[11]}}, alf_pkg::ALF_MED_NEG};
            end else begin
                gain_error = {{2{alf_pkg::ALF_MED_POS[11]}}, alf_pkg::ALF_MED_POS};
            end
        end else begin
            gain_error = true_error;
        end
    end

    // mantissa code over sixteen; median values scaled the same way
    assign product   = gain_error * $signed({1'b0, loop_gain.mant});
    assign extended  = {{13{product[18]}}, product};
    // shift right by fifteen minus the exponent code
    assign shift_amt = ~loop_gain.exp;
    // alignment sets one error unit to about 1.5 dB of gain change
    assign acc_step  = (extended <<< alf_pkg::ALF_ERR_ALIGN) >>> shift_amt;

endmodule

// ==== verilog/alf_loop_filter.sv ====
`timescale 1ns/10ps
module alf_loop_filter (
    input  wire logic             core_clk,             // Back-end processing clock
    input  wire logic             reset_n,              // Asynchronous reset, active low
    input  wire alf_pkg::alf_cw_t host_cw,              // Host control word write
    input  wire logic             loop_gain_set_select, // Pin: loop gain set select
    input  wire logic             backend_sync_input,   // Pin: back-end sync
    input  wire logic [12:0]      signal_magnitude,     // Magnitude from polar converter
    input  wire logic             sample_valid,         // One output sample per pulse
    input  wire logic             gain_load,            // New sample enters gain stage
    output logic [15:0]           gain_level,           // Limited gain, exponent over mantissa
    output logic                  median_active         // Settling mode in force
);
    alf_pkg::alf_state_t     st_q;
    alf_pkg::alf_state_t     st_d;
    alf_pkg::alf_loop_gain_t gain_sel;
    logic signed [13:0]      gain_error;
    logic signed [31:0]      acc_step;
    logic signed [32:0]      acc_sum;
    logic signed [31:0]      acc_lim;
    logic signed [31:0]      acc_stepped;
    logic signed [31:0]      lim_lo;
    logic signed [31:0]      lim_hi;
    logic                    sync_edge;
    logic                    cw_reset;
    logic                    clear_acc;

    // Limit word into accumulator units, mantissa right below exponent
    function automatic logic signed [31:0] lim_to_acc(input logic [11:0] lim,
                                                      input logic        fill);
        lim_to_acc = {1'b0, lim, (fill ? alf_pkg::ALF_LIM_FILL : 19'h00000)};
    endfunction

    // Saturate a value into the programmed gain window
    function automatic logic signed [31:0] clamp(input logic signed [32:0] v,
                                                 input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
        // Crossed limits: values below the lower bound get it, since it is tested first; all others get the upper bound
        if (v < 33'(lo)) begin
            clamp = lo;
        end else if (v > 33'(hi)) begin
            clamp = hi;
        end else begin
            clamp = v[31:0];
        end
    endfunction

    // upper limit field; its 8-bit mantissa sits below the exponent
    assign lim_hi = lim_to_acc(st_q.limit_q[alf_pkg::ALF_LIM_UP_HI:alf_pkg::ALF_LIM_UP_LO], 1'b1);
    // lower limit field in the same format
    assign lim_lo = lim_to_acc(st_q.limit_q[alf_pkg::ALF_LIM_LO_HI:alf_pkg::ALF_LIM_LO_LO], 1'b0);

    // synchronised select pin picks the stored gain set
    // both sets from the low sixteen bits of the loop word
    assign gain_sel = st_q.sel_sync_q[1] ? st_q.loop_q[alf_pkg::ALF_LG1_LO +: 8]
                                         : st_q.loop_q[alf_pkg::ALF_LG0_LO +: 8];

    alf_error_scaler u_scaler (
        .level_threshold  (st_q.loop_q[alf_pkg::ALF_THR_HI:alf_pkg::ALF_THR_LO]),
        .signal_magnitude (signal_magnitude),
        .median_mode      (st_q.median_q),
        .loop_gain        (gain_sel),
        .gain_error       (gain_error),
        .acc_step         (acc_step)
    );

    // Sync edge is read from the second stage only, so the first stays clean
    assign sync_edge = st_q.sync_sync_q[1] & ~st_q.sync_prev_q;
    assign cw_reset  = host_cw.wr && (host_cw.addr == alf_pkg::ALF_CW_BE_RESET);
    // sync always clears; reset command only when unprotected
    assign clear_acc = sync_edge || (cw_reset && !st_q.protect_q);

    // sum saturates into the window; output also clamped if limits move
    assign acc_sum     = 33'(st_q.acc_q) + 33'(acc_step);
    assign acc_stepped = clamp(acc_sum, lim_lo, lim_hi);
    assign acc_lim     = clamp(33'(st_q.acc_q), lim_lo, lim_hi);

    // Next state
    always_comb begin
        st_d = st_q;
        st_d.sel_sync_q  = {st_q.sel_sync_q[0], loop_gain_set_select};
        st_d.sync_sync_q = {st_q.sync_sync_q[0], backend_sync_input};
        st_d.sync_prev_q = st_q.sync_sync_q[1];
        if (host_cw.wr) begin
            case (host_cw.addr)
                alf_pkg::ALF_CW_LOOP: begin
                    st_d.loop_q = host_cw.data;
                end
                alf_pkg::ALF_CW_LIMIT: begin
                    st_d.limit_q = host_cw.data;
                end
                alf_pkg::ALF_CW_OPTION: begin
                    st_d.protect_q = host_cw.data[alf_pkg::ALF_PROTECT_BIT];
                    // option bit selects median or mean settling
                    st_d.median_q  = host_cw.data[alf_pkg::ALF_MEDIAN_BIT];
                end
                default: begin
                    st_d.loop_q = st_q.loop_q;
                end
            endcase
        end
        // Clear beats accumulation so a reset sample cannot leak through
        if (clear_acc) begin
            st_d.acc_q = alf_pkg::ALF_ACC_RST;
        end else if (sample_valid) begin
            st_d.acc_q = acc_stepped;
        end
        // gain stage samples the limited gain on each new input sample
        if (gain_load) begin
            st_d.gain_q = acc_lim[alf_pkg::ALF_ACC_LIM_POS + 11 -: 16];
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q.loop_q      <= alf_pkg::ALF_WORD_RST;
            st_q.limit_q     <= alf_pkg::ALF_WORD_RST;
            st_q.protect_q   <= 1'b0;
            st_q.median_q    <= 1'b0;
            st_q.sel_sync_q  <= 2'h0;
            st_q.sync_sync_q <= 2'h0;
            st_q.sync_prev_q <= 1'b0;
            st_q.acc_q       <= alf_pkg::ALF_ACC_RST;
            st_q.gain_q      <= alf_pkg::ALF_GAIN_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state register
    assign gain_level    = st_q.gain_q;
    assign median_active = st_q.median_q;

    // Checks run on the back-end clock and sleep through reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    chk_gain_window: assert property (
        gain_load && !host_cw.wr |=> (gain_level[15:4] >= $past(st_q.limit_q[11:0]))
            && (gain_level[15:4] <= $past(st_q.limit_q[27:16])))
        else $error("Gain output left the limit window");

    chk_cmd_clear: assert property (
        cw_reset && !st_q.protect_q |=> st_q.acc_q == 32'h0000_0000)
        else $error("Reset command did not clear accumulator");

    chk_protect_hold: assert property (
        cw_reset && st_q.protect_q && !sample_valid && !sync_edge |=> $stable(st_q.acc_q))
        else $error("Protected accumulator changed on reset command");

    chk_sync_clear: assert property (
        $rose(st_q.sync_sync_q[1]) |-> ##1 st_q.acc_q == 32'h0000_0000)
        else $error("Sync edge did not clear accumulator");

    chk_median_value: assert property (
        st_q.median_q |-> (gain_error == 14'sh0200) || (gain_error == 14'sh3e00))
        else $error("Median error not a fixed step");

    chk_mean_error: assert property (
        !st_q.median_q |-> gain_error == $signed({1'b0, st_q.loop_q[28:16]})
            - $signed({1'b0, signal_magnitude}))
        else $error("Mean error not threshold minus magnitude");

    chk_idle_hold: assert property (
        !sample_valid && !clear_acc |=> $stable(st_q.acc_q))
        else $error("Accumulator moved without a sample");

    chk_select_set: assert property (
        st_q.sel_sync_q[1] |-> gain_sel == st_q.loop_q[15:8])
        else $error("Select high did not pick gain set 1");

    chk_zero_gain: assert property (
        sample_valid && !clear_acc && gain_sel.mant == 4'h0
            && st_q.acc_q >= lim_lo && st_q.acc_q <= lim_hi && !host_cw.wr
            |=> $stable(st_q.acc_q))
        else $error("Zero mantissa still moved the accumulator");

    chk_gain_hold: assert property (
        !gain_load |=> $stable(gain_level))
        else $error("Gain output changed without a load");

    chk_mode_write: assert property (
        host_cw.wr && host_cw.addr == alf_pkg::ALF_CW_OPTION
            |=> median_active == $past(host_cw.data[alf_pkg::ALF_MEDIAN_BIT]))
        else $error("Option write did not set settling mode");

    chk_protect_write: assert property (
        host_cw.wr && host_cw.addr == alf_pkg::ALF_CW_OPTION
            |=> st_q.protect_q == $past(host_cw.data[alf_pkg::ALF_PROTECT_BIT]))
        else $error("Option write did not set accumulator protect");

    chk_select_low: assert property (
        !st_q.sel_sync_q[1] |-> gain_sel == st_q.loop_q[7:0])
        else $error("Select low did not pick gain set 0");

    chk_median_sign: assert property (
        st_q.median_q |-> gain_error[13]
            == (signal_magnitude > st_q.loop_q[alf_pkg::ALF_THR_HI:alf_pkg::ALF_THR_LO]))
        else $error("Median error sign does not follow true error");

    chk_limit_fields: assert property (
        host_cw.wr && host_cw.addr == alf_pkg::ALF_CW_LIMIT |=> lim_hi[30:19]
            == $past(host_cw.data[27:16]) && lim_lo[30:19] == $past(host_cw.data[11:0]))
        else $error("Limit fields not taken from their word positions");

endmodule

// ==== bench/alf_host_model.sv ====
`timescale 1ns/10ps
module alf_host_model (
    input  wire logic       core_clk, // Back-end clock
    output alf_pkg::alf_cw_t host_cw  // Control word writes
);
    // No write pending at time zero
    initial host_cw = '{wr: 1'b0, addr: 5'h00, data: 32'h0000_0000};

    // Write held from just after an edge to the edge that takes it
    task automatic write_word(input logic [4:0] a, input logic [31:0] d);
        host_cw = '{wr: 1'b1, addr: a, data: d};
        @(posedge core_clk);
        #1;
    endtask

    // Released bus shows inverted data so a stale word is never reused
    task automatic idle();
        host_cw = '{wr: 1'b0, addr: host_cw.addr, data: ~host_cw.data};
    endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb;
    logic             core_clk;
    logic             reset_n;
    logic             loop_gain_set_select;
    logic             backend_sync_input;
    logic [12:0]      signal_magnitude;
    logic             sample_valid;
    logic             gain_load;
    logic [15:0]      gain_level;
    logic             median_active;
    alf_pkg::alf_cw_t host_cw;
    logic [15:0]      lfsr;
    logic [31:0]      w8;
    logic [31:0]      w9;
    logic             med;
    longint           acc_m;
    int               num_errors;
    int               samples_checked;

    alf_host_model host_u (.core_clk(core_clk), .host_cw(host_cw));

    alf_loop_filter dut_u (
        .core_clk            (core_clk),
        .reset_n             (reset_n),
        .host_cw             (host_cw),
        .loop_gain_set_select(loop_gain_set_select),
        .backend_sync_input  (backend_sync_input),
        .signal_magnitude    (signal_magnitude),
        .sample_valid        (sample_valid),
        .gain_load           (gain_load),
        .gain_level          (gain_level),
        .median_active       (median_active)
    );

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Pseudo-random words from a fixed start
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // Step per sample: signed error times mantissa, aligned, shifted down
    function automatic longint step_f(logic [12:0] thr, logic [12:0] lvl,
                                      alf_pkg::alf_loop_gain_t g);
        logic signed [31:0] v;
        v = $signed({19'h0, thr}) - $signed({19'h0, lvl});
        if (med)
            v = (v < 0) ? -32'sh200 : 32'sh200;
        v = (v * $signed({28'h0, g.mant})) <<< 11;
        return v >>> (15 - g.exp);
    endfunction

    // Saturate to the window of the limit word
    function automatic longint clamp_f(longint a);
        longint lo;
        longint hi;
        lo = longint'({w9[11:0], 19'h00000});
        hi = longint'({w9[27:16], 19'h7ffff});
        return (a < lo) ? lo : ((a > hi) ? hi : a);
    endfunction

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    // Settling mode flag against the mode last written
    task automatic chk_mode(input logic e);
        chk({15'h0000, e}, {15'h0000, median_active});
    endtask

    // Back-to-back samples then one load; the model follows every sample
    task automatic run(input int n);
        alf_pkg::alf_loop_gain_t g;
        longint                  c;
        g = loop_gain_set_select ? w8[15:8] : w8[7:0];
        repeat (n) begin
            sample_valid = 1'b1;
            acc_m = clamp_f(acc_m + step_f(w8[28:16], signal_magnitude, g));
            tick(1);
        end
        sample_valid = 1'b0;
        gain_load = 1'b1;
        tick(1);
        gain_load = 1'b0;
        c = clamp_f(acc_m);
        chk(c[30:15], gain_level);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        logic [15:0] r;
        lfsr = 16'h5af3;
        {reset_n, loop_gain_set_select, backend_sync_input} = 3'h0;
        {sample_valid, gain_load} = 2'h0;
        signal_magnitude = 13'h0000;
        acc_m = 0;
        num_errors = 0;
        samples_checked = 0;
        w9 = 32'h0000_0000;
        tick(3);
        reset_n = 1'b1;
        chk(16'h0000, gain_level);
        chk_mode(1'b0);
        // Random words; trial 0 is full scale, trial 1 is median mode with zero true error
        for (int t = 0; t < 40; t++) begin
            r = rnd();
            w8 = (t == 0) ? 32'h1fff_ffff : {rnd(), rnd()} & 32'h1fff_ffff;
            w9 = {rnd(), rnd()} & 32'h0fff_0fff;
            w9[11:0] = w9[11:0] & w9[27:16];
            med = r[0] | (t == 1);
            loop_gain_set_select = r[1];
            signal_magnitude = (t == 1) ? w8[28:16] : 13'(rnd());
            host_u.write_word(alf_pkg::ALF_CW_LOOP, w8);
            host_u.write_word(alf_pkg::ALF_CW_LIMIT, w9);
            host_u.write_word(alf_pkg::ALF_CW_OPTION, {15'h0000, med, 16'h0000});
            host_u.idle();
            tick(3);
            chk_mode(med);
            run(1 + r[4:2]);
        end
        $display("Random trials done");
        // Wide window so a cleared accumulator shows at the output
        w8 = 32'h1fff_ffff;
        w9 = 32'h0fff_0000;
        med = 1'b0;
        signal_magnitude = 13'h0000;
        host_u.write_word(alf_pkg::ALF_CW_LOOP, w8);
        host_u.write_word(alf_pkg::ALF_CW_LIMIT, w9);
        host_u.write_word(alf_pkg::ALF_CW_OPTION, 32'h0000_8000);
        host_u.idle();
        tick(3);
        run(2);
        host_u.write_word(alf_pkg::ALF_CW_BE_RESET, 32'h0000_0000);
        host_u.idle();
        run(0);
        backend_sync_input = 1'b1;
        tick(4);
        backend_sync_input = 1'b0;
        acc_m = 0;
        run(0);
        run(2);
        host_u.write_word(alf_pkg::ALF_CW_OPTION, 32'h0000_0000);
        host_u.write_word(alf_pkg::ALF_CW_BE_RESET, 32'h0000_0000);
        host_u.idle();
        acc_m = 0;
        run(0);
        // Unmapped word: nothing stored, mode and loop word unchanged
        host_u.write_word(5'h1f, 32'hffff_ffff);
        host_u.idle();
        tick(2);
        chk_mode(1'b0);
        run(1);
        // Reset in mid-run clears stored words, accumulator and output
        reset_n = 1'b0;
        tick(1);
        reset_n = 1'b1;
        chk(16'h0000, gain_level);
        chk_mode(1'b0);
        $display("Clear tests done");
        print_verdict();
    end
endmodule
